// >>> plw_cpu_model.sv
// Processor core model issuing protected writes, ordinary writes and reads.
`timescale 1ns/1ps
module plw_cpu_model
(
    input wire logic i_clk,
    output plw_pkg::plw_prot_wr_t o_prot_wr,
    output logic o_other_wr,
    output logic o_rd,
    output logic [15:0] o_addr
);
    import plw_pkg::*;
    initial
    begin
        o_prot_wr = '0;
        o_other_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 16'h0000;
    end
    // Kind 0 is the four-byte immediate write, 1 an ordinary write, 2 a read.
    task automatic op(input int kind, input logic [7:0] imm, input logic [7:0] inv);
        @(posedge i_clk);
        #1;
        o_addr = PLW_MODE_ADDR;
        o_prot_wr = '{kind == 0, PLW_MODE_ADDR, imm, inv};
        o_other_wr = (kind == 1);
        o_rd = (kind == 2);
        @(posedge i_clk);
        #1;
        // Released lines show the inverse so a stale value is never mistaken.
        o_prot_wr = '{1'b0, ~PLW_MODE_ADDR, ~imm, ~inv};
        o_addr = ~PLW_MODE_ADDR;
        o_other_wr = 1'b0;
        o_rd = 1'b0;
    endtask
endmodule // plw_cpu_model

// >>> plw_pkg.sv
// Package of constants and carrier types for the program loop watchdog.
package plw_pkg;
    localparam logic [15:0] PLW_MODE_ADDR = 16'hffc2;
    localparam logic [7:0] PLW_MODE_RESET = 8'h00;
    localparam int PLW_RUN_BIT = 7;
    localparam int PLW_ORDER_BIT = 4;
    localparam int PLW_SEL_HIGH_BIT = 2;
    localparam int PLW_SEL_LOW_BIT = 1;
    // Writable bits of the mode register; all other bits read as zero.
    localparam logic [7:0] PLW_MODE_MASK = 8'h96;
    localparam int PLW_DIV_W = 13;
    localparam logic [3:0] PLW_SHIFT_SEL0 = 4'h9;
    localparam logic [3:0] PLW_SHIFT_SEL1 = 4'hb;
    localparam logic [3:0] PLW_SHIFT_SEL2 = 4'hc;
    localparam logic [3:0] PLW_SHIFT_SEL3 = 4'hd;
    // Width of the count-clock counter; one overflow period is 256 count clocks.
    localparam int PLW_CNT_W = 8;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] imm;
        logic [7:0] imm_inv;
    } plw_prot_wr_t;

    typedef struct packed {
        logic [7:0] mode_r;
        logic [PLW_DIV_W-1:0] div_r;
        logic [PLW_CNT_W-1:0] cnt_r;
        logic ovf_pend_r;
        logic irq_r;
        logic operr_r;
        logic [7:0] rdata_r;
    } plw_state_t;
endpackage

// >>> plw_watchdog.sv
// Program loop watchdog: protected mode register, divided counter, overflow interrupt.
`timescale 1ns/1ps
// Summary of operation
// - Missed clear overflows and raises watchdog interrupt.
// - Only complemented four-byte immediate form writes.
// - Bad complement suppresses write, raises operand error.
// - Other write kinds ignored, no exception.
// - Run bit set freezes contents until reset.
// - Setting run bit clears and starts counter.
// - Valid run write before overflow restarts count.
// - Register readable anytime without side effect.
// - Reset clears register, watchdog stopped.
// - Interval bits pick divider 2^9/11/12/13.
// - Overflow interrupt is non-maskable.
// - Bit 4 orders watchdog against NMI pin.
// - Hold overflow pending during NMI handler; behind pin request when pin first.
module plw_watchdog
#(
    // Count clocks in one overflow period; shorter values only serve to speed up tests.
    parameter int CNT_PERIOD = 1 << plw_pkg::PLW_CNT_W
)
(
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire plw_pkg::plw_prot_wr_t i_prot_wr,
    input wire logic i_other_wr,
    input wire logic [15:0] i_other_addr,
    input wire logic i_rd,
    input wire logic [15:0] i_rd_addr,
    input wire logic i_nmi_pin_req,
    input wire logic i_nmi_active,
    output logic [7:0] o_rdata,
    output logic o_operand_err,
    output logic o_watchdog_overflow_irq,
    output logic [7:0] o_watchdog_mode_control
);
    import plw_pkg::*;

    plw_state_t s_r;
    plw_state_t s_nxt;
    logic hit;
    logic good;
    logic tick;
    logic ovf;
    logic [3:0] sh;
    logic [PLW_DIV_W-1:0] lim;

    // ********************************
    // Count clock selection
    // ********************************
    function automatic logic [3:0] sel_shift(input logic [1:0] sel);
        case (sel)
            2'h0: sel_shift = PLW_SHIFT_SEL0;
            2'h1: sel_shift = PLW_SHIFT_SEL1;
            2'h2: sel_shift = PLW_SHIFT_SEL2;
            default: sel_shift = PLW_SHIFT_SEL3;
        endcase
    endfunction

    // ********************************
    // Next state
    // ********************************
    always_comb
    begin
        sh = sel_shift({s_r.mode_r[PLW_SEL_HIGH_BIT], s_r.mode_r[PLW_SEL_LOW_BIT]});
        lim = PLW_DIV_W'((14'h0001 << sh) - 14'h0001);
        s_nxt = s_r;
        hit = i_prot_wr.valid && (i_prot_wr.addr == PLW_MODE_ADDR);
        good = hit && ((i_prot_wr.imm ^ i_prot_wr.imm_inv) == 8'hff);
        s_nxt.operr_r = hit && !good;
        tick = s_r.mode_r[PLW_RUN_BIT] && (s_r.div_r == lim);
        ovf = tick && (s_r.cnt_r == PLW_CNT_W'(CNT_PERIOD - 1));
        if (good && !s_r.mode_r[PLW_RUN_BIT])
        begin
            // Ordinary moves and bit operations never reach here.
            s_nxt.mode_r = i_prot_wr.imm & PLW_MODE_MASK;
        end
        if (good && i_prot_wr.imm[PLW_RUN_BIT])
        begin
            // A restart clears both stages; locked contents stay as first written.
            s_nxt.div_r = '0;
            s_nxt.cnt_r = '0;
        end
        else if (!s_r.mode_r[PLW_RUN_BIT])
        begin
            s_nxt.div_r = '0;
            s_nxt.cnt_r = '0;
        end
        else
        begin
            s_nxt.div_r = tick ? '0 : s_r.div_r + 1'b1;
            // The last count clock of a period wraps to zero, so the next period starts at once.
            if (ovf)
            begin
                s_nxt.cnt_r = '0;
            end
            else if (tick)
            begin
                s_nxt.cnt_r = s_r.cnt_r + 1'b1;
            end
        end
        // The interrupt has no mask; it waits during the NMI handler, and behind the NMI pin when so ordered.
        s_nxt.ovf_pend_r = s_r.ovf_pend_r | ovf;
        s_nxt.irq_r = 1'b0;
        if (s_r.ovf_pend_r)
        begin
            if (!i_nmi_active && (s_r.mode_r[PLW_ORDER_BIT] || !i_nmi_pin_req))
            begin
                s_nxt.irq_r = 1'b1;
                s_nxt.ovf_pend_r = ovf;
            end
        end
        // Reads are pure; nothing in the count path looks at the read strobe.
        if (i_rd && (i_rd_addr == PLW_MODE_ADDR))
        begin
            s_nxt.rdata_r = s_r.mode_r;
        end
        else
        begin
            s_nxt.rdata_r = 8'h00;
        end
    end

    // ********************************
    // State register
    // ********************************
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            s_r <= '0;
            s_r.mode_r <= PLW_MODE_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign o_rdata = s_r.rdata_r;
    assign o_operand_err = s_r.operr_r;
    assign o_watchdog_overflow_irq = s_r.irq_r;
    assign o_watchdog_mode_control = s_r.mode_r;

    // ********************************
    // Checks
    // ********************************
    chk_run_locked: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        s_r.mode_r[PLW_RUN_BIT] |=> $stable(s_r.mode_r))
        else $error("Mode register changed after run.");

    chk_bad_write: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (hit && !good) |=> (o_operand_err && $stable(s_r.mode_r)))
        else $error("Bad protected write not flagged.");

    chk_other_ignored: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (i_other_wr && !i_prot_wr.valid) |=> ($stable(s_r.mode_r) && !o_operand_err))
        else $error("Ordinary write altered register.");

    chk_other_addr: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (i_other_wr && (i_other_addr == PLW_MODE_ADDR) && !i_prot_wr.valid)
        |=> $stable(o_watchdog_mode_control))
        else $error("Ordinary write to mode address took effect.");

    chk_fixed_zero: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (o_watchdog_mode_control & ~PLW_MODE_MASK) == 8'h00)
        else $error("Unused mode bit set.");

    chk_start_count: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (good && !s_r.mode_r[PLW_RUN_BIT] && i_prot_wr.imm[PLW_RUN_BIT])
        |=> (o_watchdog_mode_control[PLW_RUN_BIT] && s_r.cnt_r == '0 && s_r.div_r == '0))
        else $error("Start did not clear counter.");

    chk_restart: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (good && i_prot_wr.imm[PLW_RUN_BIT]) |=> (s_r.cnt_r == '0 && s_r.div_r == '0))
        else $error("Restart did not clear counter.");

    chk_stopped_idle: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        !s_r.mode_r[PLW_RUN_BIT] |-> (s_r.cnt_r == '0 && !ovf))
        else $error("Counter moved while stopped.");

    // The prescaler never runs past the terminal value of the selected interval.
    chk_div_bound: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        s_r.div_r <= lim)
        else $error("Prescaler passed its terminal value.");

    chk_ovf_irq: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (ovf && !i_nmi_active && !i_nmi_pin_req) |=> ##1 o_watchdog_overflow_irq)
        else $error("Overflow did not raise interrupt.");

    chk_irq_cause: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        o_watchdog_overflow_irq |-> $past(s_r.ovf_pend_r))
        else $error("Interrupt without overflow.");

    chk_wdt_first: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (s_r.ovf_pend_r && !i_nmi_active && s_r.mode_r[PLW_ORDER_BIT])
        |=> o_watchdog_overflow_irq)
        else $error("Watchdog first but interrupt held.");

    chk_pin_first: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (s_r.ovf_pend_r && i_nmi_pin_req && !s_r.mode_r[PLW_ORDER_BIT])
        |=> (!o_watchdog_overflow_irq && s_r.ovf_pend_r))
        else $error("Interrupt passed a pending NMI pin request.");

    chk_nmi_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        i_nmi_active |=> !o_watchdog_overflow_irq)
        else $error("Interrupt raised during NMI handler.");

    // A held overflow must survive the handler, or it would be lost silently.
    chk_pending_kept: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (s_r.ovf_pend_r && i_nmi_active) |=> s_r.ovf_pend_r)
        else $error("Pending overflow dropped during handler.");

    chk_read_value: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (i_rd && i_rd_addr == PLW_MODE_ADDR) |=> o_rdata == $past(s_r.mode_r))
        else $error("Read returned wrong value.");

    chk_read_zero: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        !(i_rd && (i_rd_addr == PLW_MODE_ADDR)) |=> (o_rdata == 8'h00))
        else $error("Read data shown without a read.");
endmodule // plw_watchdog

// >>> test_program_loop_watchdog.sv
// Self-checking bench for the program loop watchdog mode register.
`timescale 1ns/1ps
module test_program_loop_watchdog;
    import plw_pkg::*;
    logic I_CLK = 1'b0;
    logic I_NRST = 1'b0;
    // A short count period keeps every overflow inside the run budget.
    localparam int TB_PERIOD = 4;
    plw_prot_wr_t prot_wr;
    logic other_wr, rd, err, irq;
    logic nmi_req = 1'b0;
    logic nmi_act = 1'b0;
    logic [15:0] addr;
    logic [7:0] rdata, mode, v;
    logic [7:0] mode_m = 8'h00;
    int miscompares = 0;
    int num_checks = 0;
    int seed = 32'h848c;
    int n;
    initial
    begin
        forever #50 I_CLK = ~I_CLK;
    end
    plw_cpu_model u_plw_cpu_model(.i_clk(I_CLK), .o_prot_wr(prot_wr), .o_other_wr(other_wr),
        .o_rd(rd), .o_addr(addr));
    plw_watchdog #(.CNT_PERIOD(TB_PERIOD)) u_plw_watchdog(.I_CLK(I_CLK), .I_NRST(I_NRST),
        .i_prot_wr(prot_wr), .i_other_wr(other_wr), .i_other_addr(addr), .i_rd(rd),
        .i_rd_addr(addr), .i_nmi_pin_req(nmi_req), .i_nmi_active(nmi_act), .o_rdata(rdata),
        .o_operand_err(err), .o_watchdog_overflow_irq(irq), .o_watchdog_mode_control(mode));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Clocks in one overflow period, from the interval bits alone.
    function automatic int exp_period(input logic [7:0] m);
        case ({m[PLW_SEL_HIGH_BIT], m[PLW_SEL_LOW_BIT]})
            2'h0: exp_period = TB_PERIOD << PLW_SHIFT_SEL0;
            2'h1: exp_period = TB_PERIOD << PLW_SHIFT_SEL1;
            2'h2: exp_period = TB_PERIOD << PLW_SHIFT_SEL2;
            default: exp_period = TB_PERIOD << PLW_SHIFT_SEL3;
        endcase
    endfunction
    // Counts clocks until the interrupt shows, giving up after limit clocks.
    task automatic wait_irq(input int limit, output int cycles);
        cycles = 0;
        while (irq !== 1'b1 && cycles < limit)
        begin
            @(posedge I_CLK);
            #1;
            cycles++;
        end
    endtask
    task automatic reset_dut();
        I_NRST = 1'b0;
        mode_m = PLW_MODE_RESET;
        repeat (4) @(posedge I_CLK);
        #1;
        I_NRST = 1'b1;
        check("reset mode", 32'(PLW_MODE_RESET), 32'(mode));
        check("reset irq", 32'h0, 32'(irq));
    endtask
    // The model stores only while unlocked and only a complemented pair.
    task automatic pw(input int kind, input logic [7:0] imm, input logic [7:0] inv);
        logic good;
        good = (kind == 0) && ((imm ^ inv) == 8'hff);
        if (good && !mode_m[PLW_RUN_BIT])
            mode_m = imm & PLW_MODE_MASK;
        u_plw_cpu_model.op(kind, imm, inv);
        check("error", 32'(kind == 0 && !good), 32'(err));
        check("mode", 32'(mode_m), 32'(mode));
    endtask
    task automatic rdchk();
        u_plw_cpu_model.op(2, 8'h00, 8'h00);
        check("read data", 32'(mode_m), 32'(rdata));
        check("mode after read", 32'(mode_m), 32'(mode));
    endtask
    initial
    begin
        #6000000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        reset_dut();
        rdchk();
        pw(1, 8'h80, 8'h7f);
        pw(0, 8'h12, 8'h12);
        v = 8'($random(seed));
        v[PLW_RUN_BIT] = 1'b0;
        pw(0, v, ~v);
        rdchk();
        pw(0, 8'h90, 8'h6f);
        pw(0, 8'h02, 8'hfd);
        pw(0, 8'h55, 8'h55);
        rdchk();
        wait_irq(1000, n);
        check("irq before overflow", 1000, n);
        pw(0, 8'h90, 8'h6f);
        wait_irq(exp_period(mode_m) + 8, n);
        check("irq after restart", exp_period(mode_m) + 1, n);
        @(posedge I_CLK);
        #1;
        check("irq pulse", 32'h0, 32'(irq));
        nmi_req = 1'b1;
        wait_irq(exp_period(mode_m) + 8, n);
        check("irq over pin", exp_period(mode_m) - 1, n);
        nmi_req = 1'b0;
        reset_dut();
        v = 8'($random(seed));
        v[PLW_RUN_BIT] = 1'b1;
        v[PLW_ORDER_BIT] = 1'b0;
        pw(0, v, ~v);
        nmi_act = 1'b1;
        nmi_req = 1'b1;
        wait_irq(exp_period(mode_m) + 5, n);
        check("irq in handler", exp_period(mode_m) + 5, n);
        nmi_act = 1'b0;
        wait_irq(2, n);
        check("irq behind pin", 2, n);
        nmi_req = 1'b0;
        wait_irq(4, n);
        check("irq released", 1, n);
        rdchk();
        end_sim();
    end
endmodule // test_program_loop_watchdog
